// file: sbwt_host.sv
// host controller: issues burst writes and reads to the memory and keeps spacing
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module sbwt_host
  import sbwt_pkg::*;
#(
  parameter int DW = 8
) (
  input wire logic core_clk_i,               // system clock, 100 MHz
  input wire logic rst_i,                    // synchronous reset, active high
  input wire logic link_clk_i,               // memory command clock
  input wire logic link_rst_i,               // link-domain reset, active high
  input wire sbwt_pkg::sbwt_bus_t bus_i,     // software register port
  output logic [31:0] rdata_o,               // read data, one cycle after strobe
  output sbwt_pkg::sbwt_pins_t pins_o,       // memory-facing pins
  output logic [11:0] band_max_mhz_o,        // upper clock limit of the band
  output logic [7:0] rl_o                    // read latency in use
);
  import sbwt_pkg::*;

  // ----------------------------------------
  // core-side state
  // ----------------------------------------
  typedef struct packed {
    sbwt_cfg_t cfg;
    logic [15:0] addr;
    logic [4:0] fill;
    logic go_tgl;
    logic rd_op;
    logic [31:0] rdata;
    logic done_s1;
    logic done_s2;
    logic done_d;
    logic busy;
    logic [11:0] bmax;
    logic [7:0] rl;
  } sbwt_core_t;

  sbwt_core_t c_r, c_nxt;
  logic [DW-1:0] mem_rdata;
  logic mem_we;

  function automatic logic hit(input sbwt_bus_t b, input logic [3:0] off);
    hit = b.addr == off;
  endfunction

  // link-side state
  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_CMD1 = 3'b001,
    L_CMD2 = 3'b011,
    L_WAIT = 3'b010,
    L_PRE = 3'b110,
    L_BURST = 3'b111,
    L_PST = 3'b101,
    L_GAP = 3'b100
  } sbwt_lst_t;

  typedef struct packed {
    sbwt_lst_t st;
    logic go_s1;
    logic go_s2;
    logic go_d;
    logic done_tgl;
    logic [7:0] cnt;
    logic [7:0] gap;
    logic [5:0] beat;
    logic rd_op;
    logic ph;
    sbwt_pins_t pins;
  } sbwt_link_t;

  sbwt_link_t l_r, l_nxt;

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always_comb begin
    c_nxt = c_r;
    c_nxt.done_s1 = l_r.done_tgl;
    c_nxt.done_s2 = c_r.done_s1;
    c_nxt.done_d = c_r.done_s2;
    if (c_r.done_s2 != c_r.done_d) begin
      c_nxt.busy = 1'b0;
    end
    c_nxt.rl = c_r.cfg.data_bus_inversion ? SBWT_RL_DBI[c_r.cfg.band] : SBWT_RL_NODBI[c_r.cfg.band];
    c_nxt.bmax = SBWT_BAND_MAX_MHZ[c_r.cfg.band];
    c_nxt.rdata = 32'h0000_0000;
    if (bus_i.wr && !c_r.busy) begin
      if (hit(bus_i, SBWT_REG_CTRL)) begin
        c_nxt.cfg.band = bus_i.wdata[SBWT_CTRL_BAND_LSB +: 3];
        c_nxt.cfg.wl_set = bus_i.wdata[SBWT_CTRL_WLSET_BIT];
        c_nxt.cfg.data_bus_inversion = bus_i.wdata[SBWT_CTRL_DBI_BIT];
        c_nxt.cfg.pst_long = bus_i.wdata[SBWT_CTRL_PST_BIT];
        c_nxt.cfg.bl32 = bus_i.wdata[SBWT_CTRL_BL32_BIT];
        c_nxt.cfg.ap = bus_i.wdata[SBWT_CTRL_AP_BIT];
        if (bus_i.wdata[SBWT_CTRL_GO_BIT]) begin
          c_nxt.go_tgl = ~c_r.go_tgl;
          c_nxt.busy = 1'b1;
          c_nxt.rd_op = bus_i.wdata[SBWT_CTRL_RD_BIT];
          c_nxt.fill = 5'h00;
        end
      end else if (hit(bus_i, SBWT_REG_ADDR)) begin
        c_nxt.addr = {bus_i.wdata[15:4], 4'h0};
      end else if (hit(bus_i, SBWT_REG_DATA)) begin
        c_nxt.fill = c_r.fill + 5'h01;
      end
    end
    if (bus_i.rd) begin
      if (hit(bus_i, SBWT_REG_CTRL)) begin
        c_nxt.rdata = {22'h000000, c_r.rd_op, 1'b0, c_r.cfg.ap, c_r.cfg.bl32, c_r.cfg.pst_long,
                       c_r.cfg.data_bus_inversion, c_r.cfg.wl_set, c_r.cfg.band};
      end else if (hit(bus_i, SBWT_REG_ADDR)) begin
        c_nxt.rdata = {16'h0000, c_r.addr};
      end else if (hit(bus_i, SBWT_REG_STAT)) begin
        c_nxt.rdata = {27'h0000000, c_r.fill[3:0], c_r.busy};
      end else if (hit(bus_i, SBWT_REG_TIME)) begin
        c_nxt.rdata = {12'h000, c_r.bmax, c_r.rl};
      end
    end
  end

  assign mem_we = bus_i.wr && !c_r.busy && hit(bus_i, SBWT_REG_DATA);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      c_r <= '0;
    end else begin
      c_r <= c_nxt;
    end
  end

  sbwt_data_mem #(
    .DW(DW),
    .DEPTH(32),
    .AW(5)
  ) u_mem (
    .core_clk_i(core_clk_i),
    .link_clk_i(link_clk_i),
    .we_i(mem_we),
    .waddr_i(c_r.fill),
    .wdata_i(bus_i.wdata[DW-1:0]),
    .raddr_i(l_nxt.beat[4:0]),
    .rdata_o(mem_rdata)
  );

  // ----------------------------------------
  // link side; config is static while busy so it is read directly
  // ----------------------------------------
  logic [7:0] wl, bl, pst, gap_len;
  always_comb begin
    wl = c_r.cfg.wl_set ? SBWT_WL_B[c_r.cfg.band] : SBWT_WL_A[c_r.cfg.band];
    bl = c_r.cfg.bl32 ? SBWT_BL32 : SBWT_BL16;
    pst = c_r.cfg.pst_long ? SBWT_PST_LONG : SBWT_PST_SHORT;
    // writes: one more than the stricter of recovery and turnaround, or nWR with auto-precharge if longer; reads: read to precharge; whole cycles after burst
    if (l_r.rd_op) begin
      gap_len = SBWT_READ_TO_PRECHARGE_CYCLES[c_r.cfg.band] + (c_r.cfg.bl32 ? SBWT_BL32_RTP_ADD : 8'h00);
    end else begin
      gap_len = 8'h01 + (SBWT_TWR_CYC > SBWT_WRITE_TO_READ_DELAY_CYC ? SBWT_TWR_CYC : SBWT_WRITE_TO_READ_DELAY_CYC);
      if (c_r.cfg.ap && SBWT_NWR[c_r.cfg.band] > gap_len) begin
        gap_len = SBWT_NWR[c_r.cfg.band];
      end
    end
  end

  always_comb begin
    l_nxt = l_r;
    l_nxt.go_s1 = c_r.go_tgl;
    l_nxt.go_s2 = l_r.go_s1;
    l_nxt.go_d = l_r.go_s2;
    l_nxt.ph = ~l_r.ph;
    l_nxt.pins.cs = 1'b0;
    l_nxt.pins.ca = SBWT_CMD_DES;
    case (l_r.st)
      L_IDLE: begin
        l_nxt.pins.dqs_oe = 1'b0;
        l_nxt.pins.dq_oe = 1'b0;
        if (l_r.go_s2 != l_r.go_d) begin
          l_nxt.rd_op = c_r.rd_op;
          l_nxt.st = L_CMD1;
          l_nxt.pins.cs = 1'b1;
          l_nxt.pins.ca = c_r.rd_op ? SBWT_CMD_RD1 : SBWT_CMD_WR1;
          l_nxt.pins.ca[5] = c_r.cfg.bl32;
        end
      end
      L_CMD1: begin
        l_nxt.st = L_CMD2;
        l_nxt.pins.cs = 1'b1;
        l_nxt.pins.ca = SBWT_CMD_CAS2;
        l_nxt.pins.ca[5:2] = c_r.addr[9:6];
        // second half of column command completes it; latency counted from here
        l_nxt.cnt = (l_r.rd_op ? c_r.rl : wl) + SBWT_DQSS_CYC - SBWT_PRE_CYC;
      end
      L_CMD2: begin
        l_nxt.st = L_WAIT;
      end
      L_WAIT: begin
        if (l_r.cnt <= 8'h01) begin
          l_nxt.st = l_r.rd_op ? L_GAP : L_PRE;
          // cycle launched here is the first preamble period, L_PRE the second; strobe rises at its end
          l_nxt.cnt = l_r.rd_op ? bl : SBWT_PRE_CYC - 8'h01;
          l_nxt.pins.dqs_oe = !l_r.rd_op;
          l_nxt.pins.dqs_t = 1'b0;
          l_nxt.pins.dqs_c = 1'b1;
        end else begin
          l_nxt.cnt = l_r.cnt - 8'h01;
        end
      end
      L_PRE: begin
        // strobe held low through the preamble; memory read address runs one beat ahead
        l_nxt.pins.dqs_t = 1'b0;
        l_nxt.pins.dqs_c = 1'b1;
        if (l_r.cnt <= 8'h01) begin
          l_nxt.st = L_BURST;
          l_nxt.beat = 6'h00;
        end
        l_nxt.cnt = l_r.cnt - 8'h01;
      end
      L_BURST: begin
        // strobe toggles on the same edge that launches each beat, data held a full beat
        l_nxt.pins.dqs_t = ~l_r.pins.dqs_t;
        l_nxt.pins.dqs_c = ~l_r.pins.dqs_c;
        l_nxt.pins.dq = mem_rdata;
        l_nxt.pins.dq_oe = 1'b1;
        l_nxt.beat = l_r.beat + 6'h01;
        if ({2'b00, l_r.beat} == bl - 8'h01) begin
          l_nxt.st = L_PST;
          l_nxt.cnt = pst;
        end
      end
      L_PST: begin
        l_nxt.pins.dqs_t = ~l_r.pins.dqs_t;
        l_nxt.pins.dqs_c = ~l_r.pins.dqs_c;
        l_nxt.pins.dq_oe = 1'b0;
        if (l_r.cnt <= 8'h01) begin
          l_nxt.st = L_GAP;
          l_nxt.cnt = gap_len;
        end else begin
          l_nxt.cnt = l_r.cnt - 8'h01;
        end
      end
      L_GAP: begin
        l_nxt.pins.dqs_oe = 1'b0;
        if (l_r.cnt <= 8'h01) begin
          if (!l_r.rd_op || l_r.gap != 8'h00) begin
            l_nxt.st = L_IDLE;
            l_nxt.done_tgl = ~l_r.done_tgl;
            l_nxt.gap = 8'h00;
          end else begin
            l_nxt.gap = 8'h01;
            l_nxt.cnt = gap_len;
          end
        end else begin
          l_nxt.cnt = l_r.cnt - 8'h01;
        end
      end
      default: begin
        l_nxt.st = L_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata_o = c_r.rdata;
  assign pins_o = l_r.pins;
  assign band_max_mhz_o = c_r.bmax;
  assign rl_o = c_r.rl;

endmodule

// file: sbwt_pkg.sv
// package: shared constants, tables and carriers for the burst-write host controller
package sbwt_pkg;

  // ----------------------------------------
  // host register map (word offsets on the plain port)
  // ----------------------------------------
  localparam logic [3:0] SBWT_REG_CTRL = 4'h0;
  localparam logic [3:0] SBWT_REG_ADDR = 4'h1;
  localparam logic [3:0] SBWT_REG_DATA = 4'h2;
  localparam logic [3:0] SBWT_REG_STAT = 4'h3;
  localparam logic [3:0] SBWT_REG_TIME = 4'h4;

  // ctrl register fields
  localparam int SBWT_CTRL_BAND_LSB = 0;
  localparam int SBWT_CTRL_WLSET_BIT = 3;
  localparam int SBWT_CTRL_DBI_BIT = 4;
  localparam int SBWT_CTRL_PST_BIT = 5;
  localparam int SBWT_CTRL_BL32_BIT = 6;
  localparam int SBWT_CTRL_AP_BIT = 7;
  localparam int SBWT_CTRL_GO_BIT = 8;
  localparam int SBWT_CTRL_RD_BIT = 9;
  localparam logic [9:0] SBWT_CTRL_RST = 10'h000;

  // ----------------------------------------
  // latency tables, one entry per frequency band
  // ----------------------------------------
  localparam logic [7:0] SBWT_RL_NODBI [8] = '{8'h06, 8'h0A, 8'h0E, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
  localparam logic [7:0] SBWT_RL_DBI [8] = '{8'h06, 8'h0C, 8'h10, 8'h16, 8'h1C, 8'h20, 8'h24, 8'h28};
  localparam logic [7:0] SBWT_WL_A [8] = '{8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10, 8'h12};
  localparam logic [7:0] SBWT_WL_B [8] = '{8'h04, 8'h08, 8'h0C, 8'h12, 8'h16, 8'h1A, 8'h1E, 8'h22};
  localparam logic [7:0] SBWT_NWR [8] = '{8'h06, 8'h0A, 8'h10, 8'h14, 8'h18, 8'h1E, 8'h22, 8'h28};
  localparam logic [7:0] SBWT_READ_TO_PRECHARGE_CYCLES [8] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10};
  localparam logic [11:0] SBWT_BAND_MAX_MHZ [8] =
    '{12'h10A, 12'h215, 12'h320, 12'h42A, 12'h535, 12'h640, 12'h74A, 12'h855};
  localparam logic [11:0] SBWT_BAND_MIN_MHZ = 12'h00A;
  localparam logic [7:0] SBWT_BL32_RTP_ADD = 8'h08;

  // ----------------------------------------
  // timing, in link clock periods
  // ----------------------------------------
  localparam logic [7:0] SBWT_PRE_CYC = 8'h02;     // preamble, whole periods
  localparam logic [7:0] SBWT_DQSS_CYC = 8'h01;    // first strobe offset, centre of 0.75..1.25
  localparam logic [7:0] SBWT_PST_SHORT = 8'h01;   // 0.5 period postamble held one period
  localparam logic [7:0] SBWT_PST_LONG = 8'h02;    // 1.5 period postamble held two periods
  localparam logic [7:0] SBWT_TWR_CYC = 8'h06;     // write recovery, rounded up
  localparam logic [7:0] SBWT_WRITE_TO_READ_DELAY_CYC = 8'h04;    // write to read, rounded up
  localparam logic [7:0] SBWT_BL16 = 8'h10;
  localparam logic [7:0] SBWT_BL32 = 8'h20;

  // command codes on the command/address bus (reads and writes take two halves)
  localparam logic [5:0] SBWT_CMD_WR1 = 6'h04;
  localparam logic [5:0] SBWT_CMD_RD1 = 6'h02;
  localparam logic [5:0] SBWT_CMD_CAS2 = 6'h12;
  localparam logic [5:0] SBWT_CMD_PRE = 6'h10;
  localparam logic [5:0] SBWT_CMD_DES = 6'h00;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sbwt_bus_t;

  typedef struct packed {
    logic [2:0] band;
    logic wl_set;
    logic data_bus_inversion;
    logic pst_long;
    logic bl32;
    logic ap;
  } sbwt_cfg_t;

  typedef struct packed {
    logic cs;
    logic [5:0] ca;
    logic dqs_t;
    logic dqs_c;
    logic dqs_oe;
    logic [7:0] dq;
    logic dq_oe;
  } sbwt_pins_t;

endpackage

// file: sbwt_data_mem.sv
// memory: holds one burst of write data, registered read
`timescale 1ns/1ps
module sbwt_data_mem #(
  parameter int DW = 8,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic core_clk_i,        // write clock
  input wire logic link_clk_i,        // read clock
  input wire logic we_i,              // write enable
  input wire logic [AW-1:0] waddr_i,  // write index
  input wire logic [DW-1:0] wdata_i,  // write data
  input wire logic [AW-1:0] raddr_i,  // read index
  output logic [DW-1:0] rdata_o       // registered read data
);
  logic [DW-1:0] mem_r [DEPTH];
  // data is written only while the link side is idle, so the two ports never collide
  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end
  always_ff @(posedge link_clk_i) begin
    rdata_o <= mem_r[raddr_i];
  end
endmodule

// file: sbwt_host_sva.sv
// checker: link pin and register port timing
`timescale 1ns/1ps
module sbwt_host_sva
  import sbwt_pkg::*;
(
  input wire logic core_clk_i, // core clock
  input wire logic rst_i, // core reset
  input wire logic link_clk_i, // link clock
  input wire logic link_rst_i, // link reset
  input wire sbwt_pkg::sbwt_bus_t bus_i, // register port
  input wire logic [31:0] rdata_o, // read data
  input wire sbwt_pkg::sbwt_pins_t pins_o, // memory pins
  input wire logic [11:0] band_max_mhz_o, // band limit
  input wire logic [7:0] rl_o // read latency
);
  logic [7:0] run_r, run_nxt, idle_r, idle_nxt;
  // ----
  // beat run and command gap counters
  // ----
  always_comb begin
    run_nxt = pins_o.dq_oe ? run_r + 8'h01 : 8'h00;
    idle_nxt = pins_o.cs ? 8'h00 : idle_r + {7'h00, idle_r != 8'hFF};
  end
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      run_r <= 8'h00;
      idle_r <= 8'hFF;
    end else begin
      run_r <= run_nxt;
      idle_r <= idle_nxt;
    end
  end
  a_cmd_two_cyc: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    $rose(pins_o.cs) |=> pins_o.cs ##1 !pins_o.cs) else $error("command not two cycles");
  a_cmd_gap: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    $rose(pins_o.cs) |-> idle_r >= 8'h10) else $error("commands too close");
  a_pre_two: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    $rose(pins_o.dqs_oe) |-> !pins_o.dq_oe [*2] ##1 pins_o.dq_oe) else $error("preamble length");
  a_strobe_diff: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    pins_o.dqs_oe |-> pins_o.dqs_t != pins_o.dqs_c) else $error("strobe not differential");
  a_dq_in_strobe: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    pins_o.dq_oe |-> pins_o.dqs_oe) else $error("data without strobe");
  a_burst_len: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    $fell(pins_o.dq_oe) |-> run_r == 8'h10 || run_r == 8'h20) else $error("burst length");
  a_post_len: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    $fell(pins_o.dq_oe) |-> pins_o.dqs_oe ##[1:2] !pins_o.dqs_oe) else $error("postamble length");
  a_rdata_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !$past(bus_i.rd) |-> rdata_o == 32'h0) else $error("read data outside slot");
  c_burst32: cover property (@(posedge link_clk_i) $fell(pins_o.dq_oe) && run_r == 8'h20);
  c_cmd: cover property (@(posedge link_clk_i) $rose(pins_o.cs));
  c_read: cover property (@(posedge core_clk_i) bus_i.rd);
endmodule

// file: sbwt_mem_model.sv
// model: memory side, decodes commands and captures write beats
`timescale 1ns/1ps
module sbwt_mem_model
  import sbwt_pkg::*;
(
  input wire logic link_clk_i, // link clock
  input wire logic link_rst_i, // link reset
  input wire sbwt_pkg::sbwt_pins_t pins_i, // host pins
  output logic [7:0] beats_o, // beats taken
  output logic [7:0] lat_o, // edges to first beat
  output logic [7:0] n_rd_o, // reads seen
  output logic [255:0] data_o // captured bytes
);
  logic half_r, arm_r, is_wr_r;
  logic [7:0] cnt_r;
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      {half_r, arm_r, is_wr_r, cnt_r, beats_o, lat_o, n_rd_o} <= '0;
      data_o <= '0;
    end else begin
      half_r <= pins_i.cs && !half_r;
      if (pins_i.cs && !half_r)
        is_wr_r <= pins_i.ca != SBWT_CMD_RD1;
      if (pins_i.cs && half_r) begin
        arm_r <= is_wr_r;
        cnt_r <= 8'h00;
        beats_o <= 8'h00;
        n_rd_o <= n_rd_o + {7'h00, !is_wr_r};
      end else if (arm_r) begin
        cnt_r <= cnt_r + 8'h01;
        if (pins_i.dq_oe) begin
          // beat seen one edge after its launch edge, so count to the launch edge
          if (beats_o == 8'h00)
            lat_o <= cnt_r;
          data_o[{beats_o[4:0], 3'h0} +: 8] <= pins_i.dq;
          beats_o <= beats_o + 8'h01;
        end
      end
    end
  end
endmodule

// file: testbench.sv
// testbench: register port tests and burst operations
`timescale 1ns/1ps
module testbench;
  import sbwt_pkg::*;
  logic core_clk_i, link_clk_i, rst_i, link_rst_i;
  sbwt_bus_t bus;
  sbwt_pins_t pins;
  logic [31:0] rdata, v, e;
  logic [11:0] band_max;
  logic [7:0] rl, beats, lat, n_rd, wl;
  logic [255:0] cap;
  logic [9:0] ops [4] = '{10'h100, 10'h169, 10'h300, 10'h182};
  int n_mismatch = 0;
  int samples_checked = 0;
  sbwt_host i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .link_rst_i(link_rst_i),
    .bus_i(bus), .rdata_o(rdata), .pins_o(pins), .band_max_mhz_o(band_max), .rl_o(rl));
  sbwt_mem_model i_mem (.link_clk_i(link_clk_i), .link_rst_i(link_rst_i), .pins_i(pins), .beats_o(beats),
    .lat_o(lat), .n_rd_o(n_rd), .data_o(cap));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #37;
    forever #62.5 link_clk_i = ~link_clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----
  // one operation: load bytes, start, try a dropped write, wait, compare
  // ----
  task automatic run_op(input logic [9:0] c);
    int i, nb, guard;
    logic [7:0] rd0;
    nb = c[9] ? 0 : (c[6] ? 32 : 16);
    wl = c[3] ? SBWT_WL_B[c[2:0]] : SBWT_WL_A[c[2:0]];
    rd0 = n_rd;
    for (i = 0; i < nb; i++)
      wr(SBWT_REG_DATA, 32'hA0 + 32'(i));
    wr(SBWT_REG_CTRL, {22'h0, c});
    wr(SBWT_REG_ADDR, 32'h0000_0FF0);
    guard = 0;
    do begin
      rd(SBWT_REG_STAT, v);
      guard++;
    end while (v[0] !== 1'b0 && guard < 2000);
    check({31'h0, v[0]}, 32'h0);
    rd(SBWT_REG_ADDR, v);
    check(v, 32'h0000_1230);
    check({24'h0, n_rd - rd0}, {31'h0, c[9]});
    check({24'h0, beats}, 32'(nb));
    if (nb > 0)
      check({24'h0, lat}, {24'h0, wl + 8'h01});
    for (i = 0; i < nb; i++)
      check({24'h0, cap[i*8 +: 8]}, 32'hA0 + 32'(i));
  endtask
  initial begin
    bus = '0;
    rst_i = 1'b1;
    link_rst_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    // link reset must span several slow link edges
    repeat (32) @(posedge core_clk_i);
    link_rst_i <= 1'b0;
    rd(SBWT_REG_CTRL, v);
    check(v, 32'h0);
    rd(SBWT_REG_STAT, v);
    check(v, 32'h0);
    rd(4'hF, v);
    check(v, 32'h0);
    wr(SBWT_REG_ADDR, 32'h0000_1237);
    rd(SBWT_REG_ADDR, v);
    check(v, 32'h0000_1230);
    for (int b = 0; b < 8; b++) begin
      for (int d = 0; d < 2; d++) begin
        wr(SBWT_REG_CTRL, {27'h0, d[0], 1'b0, b[2:0]});
        rd(SBWT_REG_TIME, v);
        e = {12'h0, SBWT_BAND_MAX_MHZ[b], d[0] ? SBWT_RL_DBI[b] : SBWT_RL_NODBI[b]};
        check(v, e);
        check({12'h0, band_max, rl}, e);
      end
    end
    wr(SBWT_REG_CTRL, 32'h0000_00FF);
    rd(SBWT_REG_CTRL, v);
    check(v, 32'h0000_00FF);
    foreach (ops[k])
      run_op(ops[k]);
    tally_and_finish;
  end
  initial begin
    #500000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule
bind sbwt_host sbwt_host_sva u_sva (.core_clk_i(core_clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
  .link_rst_i(link_rst_i), .bus_i(bus_i), .rdata_o(rdata_o), .pins_o(pins_o), .band_max_mhz_o(band_max_mhz_o),
  .rl_o(rl_o));
